/* logic/bchan_maint_regs.svh */
// register offsets, field positions and reset values of the maintenance block
`ifndef BCHAN_MAINT_REGS_SVH
`define BCHAN_MAINT_REGS_SVH

`define ADDR_W                  8
`define OFF_UNBAL_COUNT         8'h00
`define OFF_LOOPBACK_CTRL       8'h04
`define OFF_OVERRIDE_CTRL       8'h08

`define UNBAL_COUNT_RESET       8'h00
`define UNBAL_COUNT_MAX         8'hFF
`define LOOPBACK_RESET          8'h00
`define OVERRIDE_RESET          1'b0
`define IDLE_ONES               8'hFF
`define DIFF_ZERO               8'h00
`define DIFF_ONE                8'h01

`define LB_B1_LINE_T            7
`define LB_B1_LINE_NT           6
`define LB_B2_LINE_T            5
`define LB_B2_LINE_NT           4
`define LB_B1_PORT_T            3
`define LB_B1_PORT_NT           2
`define LB_B2_PORT_T            1
`define LB_B2_PORT_NT           0
`define OVR_BIT                 7

`endif

/* logic/bchan_maint_pkg.sv */
// types shared by the maintenance block and its bench
package bchan_maint_pkg;

  // info signal levels on the line pair, in ascending order
  typedef enum logic [2:0] {
    INFO_0,
    INFO_1,
    INFO_2,
    INFO_3,
    INFO_4
  } info_e;

  // one frame's worth of b-channel octets
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
  } bchan_s;

  // wake-up tracking of the transceiver
  typedef enum logic {
    ACT_DEACTIVATED,
    ACT_AWAKE
  } act_e;

endpackage

/* logic/bchannel_loopback_and_balance_maint.sv */
// b-channel loopback, unbalanced-frame counter and activation override with apb registers
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bchan_maint_regs.svh"

module bchannel_loopback_and_balance_maint (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`ADDR_W-1:0]        paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      soft_reset,
  input  wire logic                      return_to_normal_command,
  input  wire logic                      network_side_role,
  input  wire logic                      line_pulse_pos,
  input  wire logic                      line_pulse_neg,
  input  wire logic                      line_frame_end,
  input  wire logic                      line_rx_strobe,
  input  wire bchan_maint_pkg::bchan_s   line_rx_data,
  output bchan_maint_pkg::bchan_s        line_tx_data,
  input  wire logic                      port_rx_strobe,
  input  wire bchan_maint_pkg::bchan_s   port_rx_data,
  output bchan_maint_pkg::bchan_s        port_tx_data,
  input  wire bchan_maint_pkg::info_e    rx_info,
  input  wire bchan_maint_pkg::info_e    normal_tx_info,
  input  wire logic                      deactivate,
  output bchan_maint_pkg::info_e         tx_info,
  output logic                           tx_aligned,
  output logic                           awake
);

  logic [7:0]               unbal_count_r;
  logic [7:0]               balance_r;
  logic [7:0]               balance_nxt;
  logic                     frame_unbalanced;
  logic [7:0]               loopback_r;
  logic                     override_r;
  logic [31:0]              prdata_r;
  logic                     addr_hit;
  logic                     wr_en;
  logic                     wr_count;
  logic                     wr_loop;
  logic                     wr_ovr;
  bchan_maint_pkg::bchan_s  line_rx_last_r;
  bchan_maint_pkg::bchan_s  port_rx_last_r;
  bchan_maint_pkg::bchan_s  line_tx_r;
  bchan_maint_pkg::bchan_s  port_tx_r;
  bchan_maint_pkg::info_e   tx_info_r;
  logic                     tx_aligned_r;
  bchan_maint_pkg::act_e    act_r;
  bchan_maint_pkg::act_e    act_nxt;

  // octet sent toward the line for one channel
  function automatic logic [7:0] line_tx_sel(input logic lt, input logic lnt, input logic pnt,
                                             input logic [7:0] line_b, input logic [7:0] port_b);
    if (lt || lnt) begin
      line_tx_sel = line_b;
    end else if (pnt) begin
      line_tx_sel = `IDLE_ONES;
    end else begin
      line_tx_sel = port_b;
    end
  endfunction

  // octet sent toward the serial port for one channel
  function automatic logic [7:0] port_tx_sel(input logic lnt, input logic pt, input logic pnt,
                                             input logic [7:0] line_b, input logic [7:0] port_b);
    if (pt || pnt) begin
      port_tx_sel = port_b;
    end else if (lnt) begin
      port_tx_sel = `IDLE_ONES;
    end else begin
      port_tx_sel = line_b;
    end
  endfunction

  // apb decode; the slave never waits, so every access ends in its first access cycle
  always_comb begin
    addr_hit = (paddr == `OFF_UNBAL_COUNT) || (paddr == `OFF_LOOPBACK_CTRL) ||
               (paddr == `OFF_OVERRIDE_CTRL);
    wr_en    = psel && penable && pwrite && clk_en && addr_hit;
    wr_count = wr_en && (paddr == `OFF_UNBAL_COUNT);
    wr_loop  = wr_en && (paddr == `OFF_LOOPBACK_CTRL);
    wr_ovr   = wr_en && (paddr == `OFF_OVERRIDE_CTRL);
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = prdata_r;

  // read data is captured in the setup cycle so it comes from a flip-flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        `OFF_UNBAL_COUNT:   prdata_r <= {24'h00_0000, unbal_count_r};
        `OFF_LOOPBACK_CTRL: prdata_r <= {24'h00_0000, loopback_r};
        `OFF_OVERRIDE_CTRL: prdata_r <= {24'h00_0000, override_r, 7'h00};
        default:            prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // running mark balance; pulses of both signs in one cycle cancel
  always_comb begin
    balance_nxt = balance_r;
    if (line_pulse_pos && !line_pulse_neg) begin
      balance_nxt = balance_r + `DIFF_ONE;
    end else if (line_pulse_neg && !line_pulse_pos) begin
      balance_nxt = balance_r - `DIFF_ONE;
    end
    frame_unbalanced = (balance_nxt != `DIFF_ZERO);
  end

  // eight bits of difference are ample: a frame carries far fewer marks than 128
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      balance_r <= `DIFF_ZERO;
    end else if (clk_en) begin
      if (soft_reset || line_frame_end) begin
        balance_r <= `DIFF_ZERO;
      end else begin
        balance_r <= balance_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unbal_count_r <= `UNBAL_COUNT_RESET;
    end else if (clk_en) begin
      if (soft_reset) begin
        unbal_count_r <= `UNBAL_COUNT_RESET;
      end else if (wr_count) begin
        unbal_count_r <= pwdata[7:0];
      end else if (line_frame_end && frame_unbalanced && unbal_count_r != `UNBAL_COUNT_MAX) begin
        unbal_count_r <= unbal_count_r + `DIFF_ONE;
      end
    end
  end

  // a write in the same cycle as return-to-normal loses: the command is meant to restore service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loopback_r <= `LOOPBACK_RESET;
    end else if (clk_en) begin
      if (soft_reset || return_to_normal_command) begin
        loopback_r <= `LOOPBACK_RESET;
      end else if (wr_loop) begin
        loopback_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override_r <= `OVERRIDE_RESET;
    end else if (clk_en) begin
      if (soft_reset) begin
        override_r <= `OVERRIDE_RESET;
      end else if (wr_ovr) begin
        override_r <= pwdata[`OVR_BIT];
      end
    end
  end

  // latest octets of each side, for the crossing paths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_rx_last_r <= '0;
      port_rx_last_r <= '0;
    end else if (clk_en) begin
      if (line_rx_strobe) begin
        line_rx_last_r <= line_rx_data;
      end
      if (port_rx_strobe) begin
        port_rx_last_r <= port_rx_data;
      end
    end
  end

  // line-side transmit octets, updated once per line frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_r <= '0;
    end else if (clk_en && line_rx_strobe) begin
      line_tx_r.b1 <= line_tx_sel(loopback_r[`LB_B1_LINE_T], loopback_r[`LB_B1_LINE_NT],
                                  loopback_r[`LB_B1_PORT_NT], line_rx_data.b1,
                                  port_rx_last_r.b1);
      line_tx_r.b2 <= line_tx_sel(loopback_r[`LB_B2_LINE_T], loopback_r[`LB_B2_LINE_NT],
                                  loopback_r[`LB_B2_PORT_NT], line_rx_data.b2,
                                  port_rx_last_r.b2);
    end
  end

  // port-side transmit octets, updated once per port frame; an echo shows in the cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_tx_r <= '0;
    end else if (clk_en && port_rx_strobe) begin
      port_tx_r.b1 <= port_tx_sel(loopback_r[`LB_B1_LINE_NT], loopback_r[`LB_B1_PORT_T],
                                  loopback_r[`LB_B1_PORT_NT], line_rx_last_r.b1,
                                  port_rx_data.b1);
      port_tx_r.b2 <= port_tx_sel(loopback_r[`LB_B2_LINE_NT], loopback_r[`LB_B2_PORT_T],
                                  loopback_r[`LB_B2_PORT_NT], line_rx_last_r.b2,
                                  port_rx_data.b2);
    end
  end

  assign line_tx_data = line_tx_r;
  assign port_tx_data = port_tx_r;

  // transmitted info level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_info_r    <= bchan_maint_pkg::INFO_0;
      tx_aligned_r <= 1'b0;
    end else if (clk_en) begin
      if (override_r && network_side_role) begin
        tx_info_r    <= bchan_maint_pkg::INFO_4;
        tx_aligned_r <= 1'b1;
      end else if (override_r) begin
        tx_info_r    <= bchan_maint_pkg::INFO_3;
        tx_aligned_r <= (rx_info == bchan_maint_pkg::INFO_2) ||
                        (rx_info == bchan_maint_pkg::INFO_4);
      end else begin
        tx_info_r    <= normal_tx_info;
        tx_aligned_r <= 1'b1;
      end
    end
  end

  assign tx_info    = tx_info_r;
  assign tx_aligned = tx_aligned_r;

  // wake-up from the deactivated state
  always_comb begin
    act_nxt = act_r;
    case (act_r)
      bchan_maint_pkg::ACT_DEACTIVATED: begin
        if (network_side_role) begin
          if (rx_info == bchan_maint_pkg::INFO_1) begin
            act_nxt = bchan_maint_pkg::ACT_AWAKE;
          end
        end else if (rx_info == bchan_maint_pkg::INFO_2 || rx_info == bchan_maint_pkg::INFO_4) begin
          act_nxt = bchan_maint_pkg::ACT_AWAKE;
        end
      end
      bchan_maint_pkg::ACT_AWAKE: begin
        if (deactivate) begin
          act_nxt = bchan_maint_pkg::ACT_DEACTIVATED;
        end
      end
      default: act_nxt = bchan_maint_pkg::ACT_DEACTIVATED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= bchan_maint_pkg::ACT_DEACTIVATED;
    end else if (clk_en) begin
      if (soft_reset) begin
        act_r <= bchan_maint_pkg::ACT_DEACTIVATED;
      end else begin
        act_r <= act_nxt;
      end
    end
  end

  assign awake = (act_r == bchan_maint_pkg::ACT_AWAKE);

  // checks
  property p_count_inc;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && !wr_count && line_frame_end && frame_unbalanced &&
      unbal_count_r != `UNBAL_COUNT_MAX |=> unbal_count_r == $past(unbal_count_r) + `DIFF_ONE;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter missed an unbalanced frame");

  property p_balanced_hold;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && !wr_count && !(line_frame_end && frame_unbalanced) |=> $stable(unbal_count_r);
  endproperty
  a_balanced_hold: assert property (p_balanced_hold) else $error("counter moved without cause");

  property p_count_write;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && wr_count |=> unbal_count_r == $past(pwdata[7:0]);
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write lost");

  property p_count_sat;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && !wr_count && unbal_count_r == `UNBAL_COUNT_MAX |=>
      unbal_count_r == `UNBAL_COUNT_MAX;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("counter left saturation");

  property p_b1_line_t;
    @(posedge pclk) disable iff (!presetn)
      clk_en && line_rx_strobe && loopback_r[`LB_B1_LINE_T] |=> line_tx_data.b1 == $past(line_rx_data.b1);
  endproperty
  a_b1_line_t: assert property (p_b1_line_t) else $error("b1 line echo wrong");

  property p_b1_line_nt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && port_rx_strobe && loopback_r[`LB_B1_LINE_NT] && !loopback_r[`LB_B1_PORT_T] &&
      !loopback_r[`LB_B1_PORT_NT] |=> port_tx_data.b1 == `IDLE_ONES;
  endproperty
  a_b1_line_nt: assert property (p_b1_line_nt) else $error("b1 port slot not idle ones");

  property p_b2_line_t;
    @(posedge pclk) disable iff (!presetn)
      clk_en && port_rx_strobe && loopback_r[`LB_B2_LINE_T] && loopback_r[3:0] == 4'h0 |=>
      port_tx_data.b2 == $past(line_rx_last_r.b2);
  endproperty
  a_b2_line_t: assert property (p_b2_line_t) else $error("b2 line data not on port");

  property p_b2_line_nt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && line_rx_strobe && loopback_r[`LB_B2_LINE_NT] |=> line_tx_data.b2 == $past(line_rx_data.b2);
  endproperty
  a_b2_line_nt: assert property (p_b2_line_nt) else $error("b2 line echo wrong");

  property p_b1_port_t;
    @(posedge pclk) disable iff (!presetn)
      clk_en && port_rx_strobe && loopback_r[`LB_B1_PORT_T] |=> port_tx_data.b1 == $past(port_rx_data.b1);
  endproperty
  a_b1_port_t: assert property (p_b1_port_t) else $error("b1 port echo wrong");

  property p_b1_port_nt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && line_rx_strobe && loopback_r[`LB_B1_PORT_NT] && loopback_r[7:6] == 2'b00 |=>
      line_tx_data.b1 == `IDLE_ONES;
  endproperty
  a_b1_port_nt: assert property (p_b1_port_nt) else $error("b1 line slot not idle ones");

  property p_b2_port_t;
    @(posedge pclk) disable iff (!presetn)
      clk_en && line_rx_strobe && loopback_r[`LB_B2_PORT_T] && loopback_r[5:4] == 2'b00 &&
      !loopback_r[`LB_B2_PORT_NT] |=> line_tx_data.b2 == $past(port_rx_last_r.b2);
  endproperty
  a_b2_port_t: assert property (p_b2_port_t) else $error("b2 port data not on line");

  property p_b2_port_nt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && port_rx_strobe && loopback_r[`LB_B2_PORT_NT] |=> port_tx_data.b2 == $past(port_rx_data.b2);
  endproperty
  a_b2_port_nt: assert property (p_b2_port_nt) else $error("b2 port echo wrong");

  property p_return_normal;
    @(posedge pclk) disable iff (!presetn)
      clk_en && (return_to_normal_command || soft_reset) |=> loopback_r == `LOOPBACK_RESET;
  endproperty
  a_return_normal: assert property (p_return_normal) else $error("loopback bits not cleared");

  property p_ovr_nt;
    @(posedge pclk) disable iff (!presetn)
      clk_en && override_r && network_side_role |=> tx_info == bchan_maint_pkg::INFO_4;
  endproperty
  a_ovr_nt: assert property (p_ovr_nt) else $error("network override not info 4");

  property p_ovr_te;
    @(posedge pclk) disable iff (!presetn)
      clk_en && override_r && !network_side_role |=> tx_info == bchan_maint_pkg::INFO_3;
  endproperty
  a_ovr_te: assert property (p_ovr_te) else $error("terminal override not info 3");

  property p_te_align;
    @(posedge pclk) disable iff (!presetn)
      clk_en && override_r && !network_side_role |=>
      tx_aligned == ($past(rx_info) == bchan_maint_pkg::INFO_2 || $past(rx_info) == bchan_maint_pkg::INFO_4);
  endproperty
  a_te_align: assert property (p_te_align) else $error("terminal alignment wrong");

  property p_te_wake;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && !network_side_role && !awake &&
      (rx_info == bchan_maint_pkg::INFO_2 || rx_info == bchan_maint_pkg::INFO_4) |=> awake;
  endproperty
  a_te_wake: assert property (p_te_wake) else $error("terminal did not wake");

  property p_nt_no_wake;
    @(posedge pclk) disable iff (!presetn)
      clk_en && network_side_role && !awake && rx_info != bchan_maint_pkg::INFO_1 |=> !awake;
  endproperty
  a_nt_no_wake: assert property (p_nt_no_wake) else $error("network woke without info 1");

  property p_ovr_off;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !override_r |=> tx_info == $past(normal_tx_info);
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("normal activation overridden");

  property p_one_per_frame;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_reset && !wr_count && !line_frame_end |=> $stable(unbal_count_r);
  endproperty
  a_one_per_frame: assert property (p_one_per_frame) else $error("counter moved mid frame");

endmodule
`default_nettype wire

/* test/line_port_peer.sv */
// far-side model: line peer sending marks and b octets, serial-port peer sending b octets
`timescale 1ns/1ps
`default_nettype none
module line_port_peer (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    send,
  input  wire logic [3:0]              npos,
  input  wire logic [3:0]              nneg,
  input  wire bchan_maint_pkg::bchan_s line_b,
  input  wire bchan_maint_pkg::bchan_s port_b,
  input  wire bchan_maint_pkg::info_e  info_in,
  output logic                         line_pulse_pos,
  output logic                         line_pulse_neg,
  output logic                         line_frame_end,
  output logic                         line_rx_strobe,
  output bchan_maint_pkg::bchan_s      line_rx_data,
  output logic                         port_rx_strobe,
  output bchan_maint_pkg::bchan_s      port_rx_data,
  output bchan_maint_pkg::info_e       rx_info
);
  logic [3:0]              pos_left_r;
  logic [3:0]              neg_left_r;
  logic                    active_r;
  bchan_maint_pkg::bchan_s line_hold_r;
  bchan_maint_pkg::bchan_s port_hold_r;
  assign rx_info = info_in;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_left_r <= 4'h0;
      neg_left_r <= 4'h0;
      active_r <= 1'b0;
      line_hold_r <= 16'h0000;
      port_hold_r <= 16'h0000;
      line_pulse_pos <= 1'b0;
      line_pulse_neg <= 1'b0;
      line_frame_end <= 1'b0;
      line_rx_strobe <= 1'b0;
      port_rx_strobe <= 1'b0;
      line_rx_data <= 16'h0000;
      port_rx_data <= 16'h0000;
    end else begin
      line_pulse_pos <= 1'b0;
      line_pulse_neg <= 1'b0;
      line_frame_end <= 1'b0;
      line_rx_strobe <= 1'b0;
      port_rx_strobe <= 1'b0;
      // octets hold only with the strobe; after it a changed pattern shows, so stale reuse is caught
      if (line_rx_strobe) begin
        line_rx_data <= ~line_rx_data;
        port_rx_data <= ~port_rx_data;
      end
      if (send) begin
        pos_left_r <= npos;
        neg_left_r <= nneg;
        line_hold_r <= line_b;
        port_hold_r <= port_b;
        active_r <= 1'b1;
      end else if (active_r) begin
        line_pulse_pos <= (pos_left_r != 4'h0);
        line_pulse_neg <= (neg_left_r != 4'h0);
        if (pos_left_r != 4'h0) begin
          pos_left_r <= pos_left_r - 4'h1;
        end
        if (neg_left_r != 4'h0) begin
          neg_left_r <= neg_left_r - 4'h1;
        end
        if (pos_left_r == 4'h0 && neg_left_r == 4'h0) begin
          line_frame_end <= 1'b1;
          line_rx_strobe <= 1'b1;
          port_rx_strobe <= 1'b1;
          line_rx_data <= line_hold_r;
          port_rx_data <= port_hold_r;
          active_r <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/bchannel_loopback_and_balance_maint_test.sv */
// self-checking bench for the loopback, balance counter and override block
`timescale 1ns/1ps
`default_nettype none
`include "bchan_maint_regs.svh"
module bchannel_loopback_and_balance_maint_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, soft_reset = 1'b0;
  logic return_to_normal_command = 1'b0, network_side_role = 1'b0, deactivate = 1'b0, send = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h89B2;
  logic pready, pslverr, lpos, lneg, lend, lstb, pstb, tx_aligned, awake, strobe_d = 1'b0;
  logic [3:0] npos = 4'h0, nneg = 4'h0;
  logic [7:0] lb_cur = 8'h00, cnt_exp = 8'h00;
  bchan_maint_pkg::bchan_s line_b = 16'h0, port_b = 16'h0, lrx, prx, line_tx_data, port_tx_data, el, ep;
  bchan_maint_pkg::bchan_s prev_l = 16'h0, prev_p = 16'h0;
  logic clk_en = 1'b1;
  logic [31:0] rnd;
  bchan_maint_pkg::info_e info_in = bchan_maint_pkg::INFO_0, normal_tx_info = bchan_maint_pkg::INFO_0;
  bchan_maint_pkg::info_e rx_info, tx_info;
  logic [32:0] rd_q[$];
  logic [31:0] lb_q[$];
  int num_errors = 0, check_count = 0, cycles = 0;
  always #2.5 pclk = ~pclk;
  line_port_peer u_peer (.pclk(pclk), .presetn(presetn), .send(send), .npos(npos), .nneg(nneg),
    .line_b(line_b), .port_b(port_b), .info_in(info_in), .line_pulse_pos(lpos), .line_pulse_neg(lneg),
    .line_frame_end(lend), .line_rx_strobe(lstb), .line_rx_data(lrx), .port_rx_strobe(pstb),
    .port_rx_data(prx), .rx_info(rx_info));
  bchannel_loopback_and_balance_maint u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .return_to_normal_command(return_to_normal_command),
    .network_side_role(network_side_role), .line_pulse_pos(lpos), .line_pulse_neg(lneg),
    .line_frame_end(lend), .line_rx_strobe(lstb), .line_rx_data(lrx), .line_tx_data(line_tx_data),
    .port_rx_strobe(pstb), .port_rx_data(prx), .port_tx_data(port_tx_data), .rx_info(rx_info),
    .normal_tx_info(normal_tx_info), .deactivate(deactivate), .tx_info(tx_info), .tx_aligned(tx_aligned),
    .awake(awake));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic bad(input string msg);
    num_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait; the bench timeout catches a slave that never answers
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // 0 return-to-normal, 1 deactivate, 2 soft reset
  task automatic pulse(input int w);
    @(posedge pclk);
    if (w == 0) return_to_normal_command <= 1'b1;
    else if (w == 1) deactivate <= 1'b1;
    else soft_reset <= 1'b1;
    @(posedge pclk);
    return_to_normal_command <= 1'b0;
    deactivate <= 1'b0;
    soft_reset <= 1'b0;
  endtask
  // one frame with np/nn marks and random octets; the expected echo follows the loopback setting
  task automatic frame(input logic [3:0] np, input logic [3:0] nn);
    int n;
    @(posedge pclk);
    send <= 1'b1; npos <= np; nneg <= nn; line_b <= 16'(xs()); port_b <= 16'(xs());
    @(posedge pclk);
    send <= 1'b0;
    // crossing paths carry the other side's octet of the previous frame
    el.b1 = (lb_cur[7] | lb_cur[6]) ? line_b.b1 : lb_cur[2] ? `IDLE_ONES : prev_p.b1;
    el.b2 = (lb_cur[5] | lb_cur[4]) ? line_b.b2 : lb_cur[0] ? `IDLE_ONES : prev_p.b2;
    ep.b1 = (lb_cur[3] | lb_cur[2]) ? port_b.b1 : lb_cur[6] ? `IDLE_ONES : prev_l.b1;
    ep.b2 = (lb_cur[1] | lb_cur[0]) ? port_b.b2 : lb_cur[4] ? `IDLE_ONES : prev_l.b2;
    lb_q.push_back({el, ep});
    prev_l = line_b;
    prev_p = port_b;
    if (np != nn && cnt_exp != `UNBAL_COUNT_MAX) cnt_exp++;
    n = 0;
    do begin @(posedge pclk); n++; end while (lend !== 1'b1 && n < 40);
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin num_errors++; tally_and_finish(); end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) bad("unexpected read");
      else chk({pslverr, prdata}, rd_q.pop_front());
    end
    if (strobe_d) begin
      if (lb_q.size() == 0) bad("unexpected echo");
      else chk({line_tx_data, port_tx_data}, lb_q.pop_front());
    end
    strobe_d <= lstb;
  end
  task automatic info_chk(input logic ovr, input logic nt, input bchan_maint_pkg::info_e ri,
                          input logic [2:0] e_info, input logic e_al);
    wr(`OFF_OVERRIDE_CTRL, {24'h0, ovr, 7'h0});
    @(posedge pclk);
    network_side_role <= nt; info_in <= ri; normal_tx_info <= bchan_maint_pkg::info_e'(xs() % 5);
    repeat (3) @(posedge pclk);
    chk({tx_info, tx_aligned}, {(ovr ? e_info : normal_tx_info), e_al});
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_UNBAL_COUNT, 33'h0);
    rd(`OFF_LOOPBACK_CTRL, 33'h0);
    rd(`OFF_OVERRIDE_CTRL, 33'h0);
    rd(8'h0C, 33'h1_0000_0000);
    for (int i = 0; i < 8; i++) begin
      rnd = xs();
      frame(rnd[3:0], rnd[4] ? rnd[3:0] : rnd[11:8]);
    end
    rd(`OFF_UNBAL_COUNT, {25'h0, cnt_exp});
    wr(`OFF_UNBAL_COUNT, 32'hFFFF_FFFE); cnt_exp = 8'hFE;
    frame(4'h3, 4'h1); frame(4'h0, 4'h2); frame(4'h2, 4'h2);
    rd(`OFF_UNBAL_COUNT, {25'h0, `UNBAL_COUNT_MAX});
    wr(`OFF_UNBAL_COUNT, 32'h0); cnt_exp = 8'h00;
    rd(`OFF_UNBAL_COUNT, 33'h0);
    for (int i = 0; i <= 8; i++) begin
      lb_cur = (i == 8) ? 8'h00 : 8'h01 << i;
      wr(`OFF_LOOPBACK_CTRL, {24'hFFFFFF, lb_cur});
      rd(`OFF_LOOPBACK_CTRL, {25'h0, lb_cur});
      frame(4'h1, 4'h1); frame(4'h2, 4'h2);
    end
    wr(`OFF_LOOPBACK_CTRL, 32'hFF);
    pulse(0);
    rd(`OFF_LOOPBACK_CTRL, 33'h0);
    lb_cur = 8'h00;
    info_chk(1'b1, 1'b1, bchan_maint_pkg::INFO_0, 3'd4, 1'b1);
    info_chk(1'b1, 1'b0, bchan_maint_pkg::INFO_0, 3'd3, 1'b0);
    info_chk(1'b1, 1'b0, bchan_maint_pkg::INFO_2, 3'd3, 1'b1);
    info_chk(1'b1, 1'b0, bchan_maint_pkg::INFO_4, 3'd3, 1'b1);
    info_chk(1'b0, 1'b1, bchan_maint_pkg::INFO_3, 3'd0, 1'b1);
    rd(`OFF_OVERRIDE_CTRL, 33'h0);
    for (int k = 0; k < 2; k++) begin
      pulse(1);
      network_side_role <= 1'b0; info_in <= k ? bchan_maint_pkg::INFO_4 : bchan_maint_pkg::INFO_2;
      repeat (3) @(posedge pclk);
      chk(awake, 1'b1);
      info_in <= bchan_maint_pkg::INFO_0;
    end
    pulse(1);
    network_side_role <= 1'b1; info_in <= bchan_maint_pkg::INFO_3;
    repeat (3) @(posedge pclk);
    chk(awake, 1'b0);
    info_in <= bchan_maint_pkg::INFO_1;
    repeat (3) @(posedge pclk);
    chk(awake, 1'b1);
    wr(`OFF_OVERRIDE_CTRL, 32'h80); wr(`OFF_LOOPBACK_CTRL, 32'h5A); wr(`OFF_UNBAL_COUNT, 32'h33);
    rd(`OFF_OVERRIDE_CTRL, 33'h80);
    pulse(2);
    rd(`OFF_UNBAL_COUNT, 33'h0);
    rd(`OFF_LOOPBACK_CTRL, 33'h0);
    rd(`OFF_OVERRIDE_CTRL, 33'h0);
    // a write while the block is frozen must not land
    clk_en <= 1'b0;
    wr(`OFF_UNBAL_COUNT, 32'h55);
    @(posedge pclk);
    clk_en <= 1'b1;
    rd(`OFF_UNBAL_COUNT, 33'h0);
    repeat (4) @(posedge pclk);
    if (rd_q.size() != 0 || lb_q.size() != 0) bad("results missing");
    tally_and_finish();
  end
endmodule
`default_nettype wire
